// [hw/seq_status_pkg.sv]
// package: constants, event and state carriers of the sequencer status register
package seq_status_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // register map
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 32'h007f_e080;
  localparam logic [ADDR_W-1:0] CMD_AREA_ADDR = 32'h007f_e000;

  // field positions of the status word
  localparam int POS_RAM_SINGLE = 0;
  localparam int POS_RAM_DOUBLE = 1;
  localparam int POS_PROTECT = 6;
  localparam int POS_CORE = 7;
  localparam int POS_PROG_SUSP = 8;
  localparam int POS_ERASE_SUSP = 9;
  localparam int POS_BUF_FULL = 10;
  localparam int POS_SUSP_OK = 11;
  localparam int POS_PROG_ERR = 12;
  localparam int POS_ERASE_ERR = 13;
  localparam int POS_ILLEGAL = 14;
  localparam int POS_READY = 15;

  localparam logic [DATA_W-1:0] RESERVED_MASK = 32'hffff_003c;
  localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0000_8000;

  // events and levels from the sequencer core, same clock
  typedef struct packed {
    logic cmd_accepted;       // command taken in, processing starts
    logic proc_done;          // command processing finished
    logic prog_suspended;     // program operation now suspended
    logic fstop_start;        // forced stop processing begins
    logic fstop_end;          // forced stop processing ended
    logic prog_susp_start;    // program suspend processing begins
    logic erase_susp_start;   // erase suspend processing begins
    logic resume_received;    // resume written to the command area
    logic status_clear_start; // status clear processing begins
    logic ram_single;         // corrected single-bit error in firmware ram
    logic ram_double;         // double-bit error in firmware ram
    logic protect_violation;  // overwrite protection violated
    logic core_fault;         // sequencer core processing error
    logic prog_fail;          // program operation failed
    logic erase_fail;         // erase operation failed
    logic illegal_cmd;        // illegal command or flash access
    logic buf_full;           // level: program data buffer full
    logic suspend_window;     // level: suspend command acceptable now
  } core_ev_t;

  typedef struct packed {
    logic seq_ready_flag;
    logic illegal_command_error;
    logic erase_error_flag;
    logic program_error_flag;
    logic suspend_accept_flag;
    logic write_buffer_full;
    logic erase_suspended_flag;
    logic program_suspended_flag;
    logic core_error_flag;
    logic overwrite_protect_error;
    logic fw_ram_double_error;
    logic fw_ram_single_corrected;
  } flags_t;

  typedef struct packed {
    flags_t f;
    logic locked;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
    logic wr_valid;
    logic [DATA_W-1:0] wr_data;
  } state_t;

  localparam flags_t FLAGS_RESET = '{seq_ready_flag: 1'b1, default: 1'b0};

endpackage

// [hw/seq_status.sv]
// sequencer status register with apb slave and command-area write stall
//////////////////////////////////////////////////////////////////////////////
// Function
// RL1 - reserved bits 31..16 and 5..2 always read as zero
// RL2 - after reset ready reads one, all other flags zero
// RL3 - bit 15 ready reads zero while any sequencer command executes
// RL4 - ready sets on completion, program suspension, or forced stop end
// RL5 - bit 0 sets on corrected firmware ram error; does not lock
// RL6 - bit 1 sets on firmware ram double error; locks while set
// RL7 - both firmware ram flags clear when forced stop begins
// RL8 - bit 6 sets on overwrite protection violation; locks while set
// RL9 - bit 7 sets on sequencer core error; locks while set
// RL10 - protection and core error flags clear when forced stop begins
// RL11 - software answers core or ram errors with forced stop and reload
// RL12 - bit 8 sets at program suspend start, holds while suspended
// RL13 - bit 9 sets at erase suspend start, holds while suspended
// RL14 - suspend flags clear on resume received or forced stop start
// RL15 - bit 10 shows whether the program data buffer is full
// RL16 - command area data writes wait while the buffer is full
// RL17 - bit 11 reads one only while a suspend command is acceptable
// RL18 - bits 12 and 13 report failed program and erase operations
// RL19 - bit 14 sets on illegal command or illegal flash access
// RL20 - error flags 12..14 clear on status clear or forced stop start
// RL21 - writes to the status register change no flag
//
// The implementer's own choice: register access over APB.
module seq_status (
  input wire logic pclk, // system clock, 25 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [seq_status_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [seq_status_pkg::DATA_W-1:0] pwdata, // apb write data
  output logic [seq_status_pkg::DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb transfer done
  output logic pslverr, // apb error, unmapped address or read of the command area
  input wire seq_status_pkg::core_ev_t ev, // events from sequencer core
  output logic command_locked, // sequencer is command-locked
  output logic seq_ready, // ready flag copy for the core
  output logic cmd_wr_valid, // one-cycle pulse: data write to command area
  output logic [seq_status_pkg::DATA_W-1:0] cmd_wr_data // data of that write
);
  import seq_status_pkg::*;

  state_t s;
  state_t next_s;

  function automatic logic [DATA_W-1:0] pack_status(input flags_t f);
    logic [DATA_W-1:0] w;
    w = '0; // reserved bits stay zero RL1
    w[POS_RAM_SINGLE] = f.fw_ram_single_corrected;
    w[POS_RAM_DOUBLE] = f.fw_ram_double_error;
    w[POS_PROTECT] = f.overwrite_protect_error;
    w[POS_CORE] = f.core_error_flag;
    w[POS_PROG_SUSP] = f.program_suspended_flag;
    w[POS_ERASE_SUSP] = f.erase_suspended_flag;
    w[POS_BUF_FULL] = f.write_buffer_full;
    w[POS_SUSP_OK] = f.suspend_accept_flag;
    w[POS_PROG_ERR] = f.program_error_flag;
    w[POS_ERASE_ERR] = f.erase_error_flag;
    w[POS_ILLEGAL] = f.illegal_command_error;
    w[POS_READY] = f.seq_ready_flag;
    return w;
  endfunction

  // a flag that hardware sets keeps the set when a clear lands in the same cycle
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic access;
  logic hit_status;
  logic hit_cmd;
  logic stall;
  logic err_clear;

  always_comb begin
    next_s = s;
    access = psel & penable & ~s.pready;
    hit_status = (paddr == STATUS_ADDR);
    hit_cmd = (paddr == CMD_AREA_ADDR);
    // program data must not overrun the buffer, so the bus waits instead
    stall = pwrite & hit_cmd & s.f.write_buffer_full; // RL16
    err_clear = ev.status_clear_start | ev.fstop_start;

    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.prdata = '0;
    next_s.wr_valid = 1'b0;
    if (access && !stall) begin
      next_s.pready = 1'b1;
      if (!hit_status && !(hit_cmd && pwrite)) begin
        next_s.pslverr = 1'b1;
      end
      if (!pwrite && hit_status) begin
        next_s.prdata = pack_status(s.f); // RL1
      end
      if (pwrite && hit_cmd) begin
        next_s.wr_valid = 1'b1;
        next_s.wr_data = pwdata;
      end
      // a write to the status address itself is accepted and dropped RL21
    end

    next_s.f.seq_ready_flag = sticky(s.f.seq_ready_flag,
      ev.proc_done | ev.prog_suspended | ev.fstop_end, ev.cmd_accepted); // RL3 RL4
    next_s.f.fw_ram_single_corrected = sticky(s.f.fw_ram_single_corrected,
      ev.ram_single, ev.fstop_start); // RL5 RL7
    next_s.f.fw_ram_double_error = sticky(s.f.fw_ram_double_error,
      ev.ram_double, ev.fstop_start); // RL6 RL7
    next_s.f.overwrite_protect_error = sticky(s.f.overwrite_protect_error,
      ev.protect_violation, ev.fstop_start); // RL8 RL10
    next_s.f.core_error_flag = sticky(s.f.core_error_flag,
      ev.core_fault, ev.fstop_start); // RL9 RL10
    next_s.f.program_suspended_flag = sticky(s.f.program_suspended_flag,
      ev.prog_susp_start, ev.resume_received | ev.fstop_start); // RL12 RL14
    next_s.f.erase_suspended_flag = sticky(s.f.erase_suspended_flag,
      ev.erase_susp_start, ev.resume_received | ev.fstop_start); // RL13 RL14
    next_s.f.write_buffer_full = ev.buf_full; // RL15
    next_s.f.suspend_accept_flag = ev.suspend_window; // RL17
    next_s.f.program_error_flag = sticky(s.f.program_error_flag,
      ev.prog_fail, err_clear); // RL18 RL20
    next_s.f.erase_error_flag = sticky(s.f.erase_error_flag,
      ev.erase_fail, err_clear); // RL18 RL20
    next_s.f.illegal_command_error = sticky(s.f.illegal_command_error,
      ev.illegal_cmd, err_clear); // RL19 RL20

    // the single-bit monitor is left out: a corrected error needs no lock
    next_s.locked = next_s.f.fw_ram_double_error | next_s.f.overwrite_protect_error
      | next_s.f.core_error_flag | next_s.f.program_error_flag
      | next_s.f.erase_error_flag | next_s.f.illegal_command_error; // RL5 RL6 RL8 RL9
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{f: FLAGS_RESET, default: '0}; // RL2
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign command_locked = s.locked;
  assign seq_ready = s.f.seq_ready_flag;
  assign cmd_wr_valid = s.wr_valid;
  assign cmd_wr_data = s.wr_data;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic no_ready_set;
  logic no_err_set;
  logic no_fatal_set;
  assign no_ready_set = ~(ev.proc_done | ev.prog_suspended | ev.fstop_end);
  assign no_err_set = ~(ev.prog_fail | ev.erase_fail | ev.illegal_cmd);
  assign no_fatal_set = ~(ev.ram_single | ev.ram_double | ev.protect_violation
    | ev.core_fault | ev.prog_susp_start | ev.erase_susp_start);

  sequence prog_susp_begin;
    ev.prog_susp_start;
  endsequence

  sequence no_susp_clear_3;
    (!ev.resume_received && !ev.fstop_start)[*3];
  endsequence

  sequence erase_susp_begin;
    ev.erase_susp_start;
  endsequence

  sequence status_read_done;
    psel && penable && !pwrite && (paddr == STATUS_ADDR) && !s.pready;
  endsequence

  AST_RESERVED_ZERO: assert property ((prdata & RESERVED_MASK) == '0) // RL1
    else $error("reserved status bits read nonzero");

  AST_READ_READY: assert property (status_read_done |=>
    pready && prdata[POS_READY] == $past(s.f.seq_ready_flag)) // RL3
    else $error("status read did not return ready flag");

  AST_READY_CLEAR: assert property (ev.cmd_accepted && no_ready_set |=> !seq_ready) // RL3
    else $error("ready not cleared by accepted command");

  AST_READY_SET: assert property (!no_ready_set |=> seq_ready) // RL4
    else $error("ready not set on completion");

  AST_SINGLE_NO_LOCK: assert property (ev.ram_single && !command_locked && no_err_set
    && !ev.ram_double && !ev.protect_violation && !ev.core_fault
    |=> s.f.fw_ram_single_corrected && !command_locked) // RL5
    else $error("single-bit monitor wrongly locked or not set");

  AST_LOCK_FLAGS: assert property (s.f.fw_ram_double_error || s.f.overwrite_protect_error
    || s.f.core_error_flag |-> command_locked) // RL6
    else $error("fatal flag set without command lock");

  AST_FSTOP_CLEAR: assert property (ev.fstop_start && no_fatal_set && no_err_set
    |=> !s.f.fw_ram_single_corrected && !s.f.fw_ram_double_error
    && !s.f.overwrite_protect_error && !s.f.core_error_flag
    && !s.f.program_suspended_flag && !s.f.erase_suspended_flag
    && !command_locked) // RL7
    else $error("forced stop did not clear flags");

  AST_FATAL_SET: assert property (ev.protect_violation || ev.core_fault
    |=> command_locked ##1 $past(s.f.overwrite_protect_error || s.f.core_error_flag)) // RL8
    else $error("protection or core error not raised");

  AST_PROG_SUSP_HOLD: assert property (prog_susp_begin ##1 no_susp_clear_3
    |-> s.f.program_suspended_flag) // RL12
    else $error("program suspend flag not held");

  AST_ERASE_SUSP_HOLD: assert property (erase_susp_begin ##1 no_susp_clear_3
    |-> s.f.erase_suspended_flag) // RL13
    else $error("erase suspend flag not held");

  AST_RESUME_CLEAR: assert property (ev.resume_received && !ev.prog_susp_start
    && !ev.erase_susp_start |=> !s.f.program_suspended_flag
    && !s.f.erase_suspended_flag) // RL14
    else $error("resume did not clear suspend flags");

  AST_LEVELS: assert property (1'b1 |=> s.f.write_buffer_full == $past(ev.buf_full)
    && s.f.suspend_accept_flag == $past(ev.suspend_window)) // RL15
    else $error("buffer or suspend level not tracked");

  AST_BUF_STALL: assert property (psel && penable && pwrite && (paddr == CMD_AREA_ADDR)
    && s.f.write_buffer_full && !pready |=> !pready && !cmd_wr_valid) // RL16
    else $error("command area write not stalled while buffer full");

  AST_FAIL_SET: assert property (ev.prog_fail && ev.erase_fail
    |=> s.f.program_error_flag && s.f.erase_error_flag && command_locked) // RL18
    else $error("failure flags not raised");

  AST_ILLEGAL_SET: assert property (ev.illegal_cmd |=> s.f.illegal_command_error [*1]
    ##0 command_locked) // RL19
    else $error("illegal command flag not raised");

  AST_CLEAR_ERRS: assert property (ev.status_clear_start && no_err_set
    |=> !s.f.program_error_flag && !s.f.erase_error_flag
    && !s.f.illegal_command_error) // RL20
    else $error("status clear did not clear error flags");

  AST_WRITE_NO_EFFECT: assert property (psel && penable && pwrite && !pready
    && (paddr == STATUS_ADDR) && ev == '0 && !s.f.write_buffer_full
    && !s.f.suspend_accept_flag |=> s.f == $past(s.f)) // RL21
    else $error("status register write changed a flag");

endmodule

// [testbench/seq_status_test.sv]
// self-checking bench of the sequencer status register over apb
module seq_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  import seq_status_pkg::*;

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("FAIL at %0t: got %h expected %h", $time, (a), (b)); end end

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  core_ev_t ev = '0;
  logic command_locked;
  logic seq_ready;
  logic cmd_wr_valid;
  logic [DATA_W-1:0] cmd_wr_data;
  int failures = 0;
  int cmp_count = 0;
  int n;
  int i;
  logic [17:0] lv = '0;
  logic [DATA_W-1:0] r;
  logic [DATA_W-1:0] b;
  logic e;
  logic wv;
  int src[9] = '{8, 7, 6, 5, 12, 11, 4, 3, 2};
  int pos[9] = '{POS_RAM_SINGLE, POS_RAM_DOUBLE, POS_PROTECT, POS_CORE, POS_PROG_SUSP,
    POS_ERASE_SUSP, POS_PROG_ERR, POS_ERASE_ERR, POS_ILLEGAL};

  always #20 pclk = ~pclk;

  seq_status dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev(ev), .command_locked(command_locked), .seq_ready(seq_ready),
    .cmd_wr_valid(cmd_wr_valid), .cmd_wr_data(cmd_wr_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // values read right after a rising edge are the ones that edge sampled
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    while (n < 200) begin
      @(posedge pclk);
      n++;
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      failures++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    wv = cmd_wr_valid;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(r, x)
    `CHK(e, xe)
  endtask

  // one-cycle event pulse on top of the current levels
  task automatic fire(input logic [17:0] m);
    @(posedge pclk);
    ev <= core_ev_t'(m | lv);
    @(posedge pclk);
    ev <= core_ev_t'(lv);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(seq_ready, 1'b1)
    rd(STATUS_ADDR, STATUS_RESET, 1'b0);
    `CHK(n, 2)
    `CHK(command_locked, 1'b0)
    apb(1'b1, STATUS_ADDR, 32'hffff_ffff);
    `CHK(e, 1'b0)
    rd(STATUS_ADDR, STATUS_RESET, 1'b0);
    rd(32'h007f_e084, 32'h0000_0000, 1'b1);
    rd(CMD_AREA_ADDR, 32'h0000_0000, 1'b1);
    $display("test reset and access done");
    // every sticky flag through its set and clear events
    for (i = 0; i < 9; i++) begin
      b = 32'h0000_0001 << pos[i];
      fire(18'h1 << src[i]);
      rd(STATUS_ADDR, STATUS_RESET | b, 1'b0);
      `CHK(command_locked, (pos[i] inside {1, 6, 7, 12, 13, 14}))
      fire(18'h1 << 9);
      rd(STATUS_ADDR, (pos[i] >= 12) ? STATUS_RESET : STATUS_RESET | b, 1'b0);
      fire(18'h1 << 10);
      rd(STATUS_ADDR, (pos[i] inside {8, 9, 12, 13, 14}) ? STATUS_RESET : STATUS_RESET | b,
        1'b0);
      fire(18'h1 << 14);
      rd(STATUS_ADDR, STATUS_RESET, 1'b0);
      `CHK(command_locked, 1'b0)
    end
    $display("test sticky flags done");
    // ready cleared on command accept, set by each of its three completion events
    for (i = 0; i < 3; i++) begin
      fire(18'h1 << 17);
      rd(STATUS_ADDR, 32'h0000_0000, 1'b0);
      `CHK(seq_ready, 1'b0)
      fire(18'h1 << (16 - i + ((i == 2) ? -1 : 0)));
      rd(STATUS_ADDR, STATUS_RESET, 1'b0);
      `CHK(seq_ready, 1'b1)
    end
    fire(18'h3_fffc);
    lv = 18'h0_0003;
    fire(18'h0_0000);
    rd(STATUS_ADDR, 32'h0000_ffc3, 1'b0);
    fire(18'h0_4000);
    rd(STATUS_ADDR, 32'h0000_8c00, 1'b0);
    $display("test ready and levels done");
    // data write into the command area while the buffer is full must wait
    fork
      apb(1'b1, CMD_AREA_ADDR, 32'ha5c3_0f96);
      begin
        repeat (8) @(posedge pclk);
        lv = 18'h0_0000;
        ev <= '0;
      end
    join
    `CHK(n > 4, 1'b1)
    `CHK(wv, 1'b1)
    `CHK(cmd_wr_data, 32'ha5c3_0f96)
    rd(STATUS_ADDR, STATUS_RESET, 1'b0);
    apb(1'b1, CMD_AREA_ADDR, 32'h0123_4567);
    `CHK(n, 2)
    `CHK(wv, 1'b1)
    `CHK(cmd_wr_data, 32'h0123_4567)
    $display("test buffer stall done");
    stop_test();
  end
endmodule
